// *** dbr_ctl.sv ***
`timescale 1ns/10ps
module dbr_ctl (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command bus
  dbr_if.ctl bus,
  // refresh setup
  input wire logic [2:0] fgr_mode_cfg,
  input wire logic pull_en,
  // access requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ap,
  input wire logic [1:0] req_bg,
  input wire logic [1:0] req_ba,
  input wire logic [dbr_pkg::ROW_W-1:0] req_row,
  input wire logic [dbr_pkg::COL_W-1:0] req_col,
  output logic req_ready,
  // refresh status
  output logic signed [6:0] ref_debt,
  output logic ref_active
);
  import dbr_pkg::*;

  typedef enum logic {
    C_RUN = 1'b0,
    C_RFC = 1'b1
  } dbr_cst_t;

  dbr_cst_t st;
  logic [NBANK-1:0] open;
  logic [ROW_W-1:0] row [NBANK];
  logic [TMR_W-1:0] bwait [NBANK];
  logic [TMR_W-1:0] rrd_s;
  logic [TMR_W-1:0] rrd_l [NBG];
  logic [TMR_W-1:0] faw [4];
  logic [TMR_W-1:0] ccd;
  logic [TMR_W-1:0] rfc;
  logic [TMR_W-1:0] refi;
  logic [1:0] shift;
  logic signed [6:0] lim;
  logic all_ready;
  logic need_ref;
  logic tick;
  logic [3:0] b;
  dbr_cmd_t next_cmd;
  logic [17:0] next_addr;
  logic do_act;
  logic do_pre;
  logic do_pall;
  logic do_rw;
  logic do_ref;
  logic [TMR_W-1:0] gap;
  logic gap_due;

  assign b = {req_bg, req_ba};
  // on-the-fly modes always run at the finer rate (bg0 set)
  assign shift = dbr_shift(fgr_mode_cfg, 1'b1);
  assign lim = 7'(POST_BASE) <<< shift;
  assign ref_active = (st == C_RFC);

  always_comb begin
    all_ready = 1'b1;
    for (int i = 0; i < NBANK; i++)
      if (bwait[i] != '0)
        all_ready = 1'b0;
  end

  // owed refresh forces the sequence; idle time pays or pulls ahead
  assign need_ref = (ref_debt >= lim) || gap_due // RULE_17 RULE_18
      || (!req_valid && ref_debt > 7'sd0) // RULE_16
      || (!req_valid && pull_en && ref_debt > -lim); // RULE_19 RULE_20

  // choose the one command of this cycle
  always_comb begin
    next_cmd = CMD_DES;
    next_addr = '0;
    do_act = 1'b0;
    do_pre = 1'b0;
    do_pall = 1'b0;
    do_rw = 1'b0;
    do_ref = 1'b0;
    req_ready = 1'b0;
    if (st == C_RFC) begin
      next_cmd = CMD_DES; // RULE_15
    end else if (need_ref) begin
      if (open != '0) begin
        next_cmd = CMD_PRE;
        next_addr[AP_BIT] = 1'b1;
        do_pall = 1'b1;
      end else if (all_ready) begin
        next_cmd = CMD_REF; // RULE_12
        do_ref = 1'b1;
      end
    end else if (req_valid) begin
      if (open[b] && row[b] == req_row) begin
        if (bwait[b] == '0 && ccd == '0) begin
          next_cmd = req_write ? CMD_WR : CMD_RD; // RULE_07
          next_addr[COL_W-1:0] = req_col;
          next_addr[AP_BIT] = req_ap;
          do_rw = 1'b1;
          req_ready = 1'b1;
        end
      end else if (open[b]) begin
        if (bwait[b] == '0) begin
          next_cmd = CMD_PRE; // RULE_02
          do_pre = 1'b1;
        end
      end else if (bwait[b] == '0 && rrd_s == '0 &&
          rrd_l[req_bg] == '0 && faw[3] == '0) begin
        next_cmd = CMD_ACT; // RULE_03 RULE_04
        next_addr = req_row;
        do_act = 1'b1;
      end
    end
    if (next_cmd != CMD_ACT)
      next_addr[16:14] = dbr_rcw(next_cmd);
  end

  // registered command bus
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus.cs_n <= 1'b1;
      bus.act_n <= 1'b1;
      bus.bg <= 2'h0;
      bus.ba <= 2'h0;
      bus.addr <= 18'h1C000;
      bus.fgr_mode <= FGR_1X;
    end else begin
      bus.cs_n <= (next_cmd == CMD_DES);
      bus.act_n <= (next_cmd != CMD_ACT);
      bus.bg <= do_ref ? 2'h1 : req_bg;
      bus.ba <= req_ba;
      bus.addr <= next_addr;
      bus.fgr_mode <= fgr_mode_cfg; // RULE_21
    end
  end

  // open rows and per-bank wait times
  always_ff @(posedge core_clk) begin
    if (reset) begin
      open <= '0;
      for (int i = 0; i < NBANK; i++) begin
        row[i] <= '0;
        bwait[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NBANK; i++)
        if (bwait[i] != '0)
          bwait[i] <= bwait[i] - 1'b1;
      if (do_pall) begin
        open <= '0;
        for (int i = 0; i < NBANK; i++)
          bwait[i] <= TMR_W'(T_RP_CYC); // RULE_05 RULE_12
      end
      if (do_pre) begin
        open[b] <= 1'b0;
        bwait[b] <= TMR_W'(T_RP_CYC); // RULE_05
      end
      if (do_act) begin
        open[b] <= 1'b1;
        row[b] <= req_row;
        bwait[b] <= TMR_W'(T_RCD_CYC);
      end
      // auto-precharge: bank closes, reuse after restore plus tRP
      if (do_rw && req_ap) begin
        open[b] <= 1'b0;
        bwait[b] <= req_write ? TMR_W'(T_WRAP_CYC + T_RP_CYC)
                              : TMR_W'(T_RTP_CYC + T_RP_CYC);
      end
    end
  end

  // activate spacing and four-activate window
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rrd_s <= '0;
      for (int i = 0; i < NBG; i++)
        rrd_l[i] <= '0;
      for (int i = 0; i < 4; i++)
        faw[i] <= '0;
    end else begin
      if (rrd_s != '0)
        rrd_s <= rrd_s - 1'b1;
      for (int i = 0; i < NBG; i++)
        if (rrd_l[i] != '0)
          rrd_l[i] <= rrd_l[i] - 1'b1;
      for (int i = 0; i < 4; i++)
        if (faw[i] != '0)
          faw[i] <= faw[i] - 1'b1;
      if (do_act) begin
        rrd_s <= TMR_W'(T_RRD_S_CYC); // RULE_03
        rrd_l[req_bg] <= TMR_W'(T_RRD_L_CYC);
        // newest window in slot 0; slot 3 is the fourth back
        faw[0] <= TMR_W'(T_FAW_CYC); // RULE_04
        for (int i = 1; i < 4; i++)
          faw[i] <= (faw[i-1] != '0) ? faw[i-1] - 1'b1 : '0;
      end
    end
  end

  // data bus spacing lets another bank run during auto-precharge
  always_ff @(posedge core_clk) begin
    if (reset)
      ccd <= '0;
    else if (do_rw)
      ccd <= TMR_W'(T_BURST_CYC - 1); // RULE_10
    else if (ccd != '0)
      ccd <= ccd - 1'b1;
  end

  // refresh cycle wait: deselect only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= C_RUN;
      rfc <= '0;
    end else begin
      unique case (st)
        C_RUN: begin
          if (do_ref) begin
            st <= C_RFC;
            rfc <= TMR_W'(T_RFC_CYC - 1);
          end
        end
        C_RFC: begin
          if (rfc == '0)
            st <= C_RUN; // RULE_15
          else
            rfc <= rfc - 1'b1;
        end
      endcase
    end
  end

  // interval timer, scaled to the refresh rate
  always_ff @(posedge core_clk) begin
    if (reset)
      refi <= TMR_W'(T_REFI_CYC - 1);
    else if (refi == '0)
      refi <= TMR_W'((T_REFI_CYC >> shift) - 1);
    else
      refi <= refi - 1'b1;
  end
  assign tick = (refi == '0);

  // refresh age guard: pull-ins must not stretch one gap too far
  always_ff @(posedge core_clk) begin
    if (reset || do_ref)
      gap <= '0;
    else if (!gap_due)
      gap <= gap + 1'b1;
  end
  assign gap_due = (gap >= TMR_W'(POST_BASE * T_REFI_CYC)); // RULE_18

  // signed debt: intervals owed minus refreshes sent
  always_ff @(posedge core_clk) begin
    if (reset)
      ref_debt <= 7'sd0;
    else if (tick && !do_ref)
      ref_debt <= ref_debt + 7'sd1; // RULE_24
    else if (do_ref && !tick && ref_debt > -lim)
      ref_debt <= ref_debt - 7'sd1; // RULE_19
  end
endmodule : dbr_ctl

// *** dbr_dev.sv ***
`timescale 1ns/10ps
module dbr_dev (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command bus
  dbr_if.dev bus,
  // state seen by the user
  output logic [dbr_pkg::NBANK-1:0] bank_open,
  output logic [dbr_pkg::REF_W-1:0] ref_row,
  output logic [1:0] ref_shift,
  output logic ref_busy,
  output logic cmd_err
);
  import dbr_pkg::*;

  dbr_cmd_t cmd;
  logic [3:0] sel;
  logic [NBANK-1:0] bank_idle;
  logic [TMR_W-1:0] rfc_cnt;
  dbr_bank_t st [NBANK];
  logic [ROW_W-1:0] row [NBANK];
  logic [TMR_W-1:0] tmr [NBANK];
  logic [NBANK-1:0] ap;
  logic bad;

  assign cmd = dbr_decode(bus.cs_n, bus.act_n, bus.addr[16:14]);
  assign sel = {bus.bg, bus.ba};

  // one state machine per bank
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      logic hit;
      assign hit = (sel == 4'(g));
      assign bank_open[g] = (st[g] == BK_OPEN);
      // last cycle of the precharge time already counts as idle, so an
      // activate or refresh spaced by exactly tRP is not refused
      assign bank_idle[g] = (st[g] == BK_IDLE) ||
          (st[g] == BK_PRE && tmr[g] <= TMR_W'(1));
      always_ff @(posedge core_clk) begin // RULE_23
        if (reset) begin
          st[g] <= BK_IDLE;
          row[g] <= '0;
          tmr[g] <= '0;
          ap[g] <= 1'b0;
        end else begin
          if (tmr[g] != '0)
            tmr[g] <= tmr[g] - 1'b1;
          if (cmd == CMD_ACT && hit && bank_idle[g]) begin
            st[g] <= BK_OPEN; // RULE_01
            row[g] <= bus.addr;
          end else if (cmd == CMD_PRE && (hit || bus.addr[AP_BIT])) begin
            // a repeated precharge restarts the recovery time
            if (st[g] != BK_IDLE) begin
              st[g] <= BK_PRE; // RULE_05 RULE_06
              tmr[g] <= TMR_W'(T_RP_CYC);
              ap[g] <= 1'b0;
            end
          end else if ((cmd == CMD_RD || cmd == CMD_WR) && hit &&
              st[g] == BK_OPEN && bus.addr[AP_BIT] && !ap[g]) begin
            // hold the precharge until restore or write data lands
            ap[g] <= 1'b1; // RULE_08
            tmr[g] <= (cmd == CMD_WR) ? TMR_W'(T_WRAP_CYC) // RULE_09
                                      : TMR_W'(T_RTP_CYC);
          end else if (st[g] == BK_OPEN && ap[g] && tmr[g] == '0) begin
            st[g] <= BK_PRE;
            tmr[g] <= TMR_W'(T_RP_CYC);
            ap[g] <= 1'b0;
          end else if (st[g] == BK_PRE && tmr[g] == '0) begin
            st[g] <= BK_IDLE;
          end
          if (rfc_cnt == TMR_W'(1))
            st[g] <= BK_IDLE; // RULE_14
        end
      end
    end
  endgenerate

  // refresh cycle timer and internal row counter
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rfc_cnt <= '0;
      ref_row <= '0;
      ref_shift <= 2'h0;
    end else if (cmd == CMD_REF && rfc_cnt == '0) begin
      rfc_cnt <= TMR_W'(T_RFC_CYC);
      ref_row <= ref_row + 1'b1; // RULE_13
      ref_shift <= dbr_shift(bus.fgr_mode, bus.bg[0]); // RULE_22
    end else if (rfc_cnt != '0) begin
      rfc_cnt <= rfc_cnt - 1'b1;
    end
  end
  assign ref_busy = (rfc_cnt != '0);

  // legality of the command against the bank states
  always_comb begin
    bad = 1'b0;
    if (ref_busy)
      bad = !(cmd == CMD_DES || cmd == CMD_NOP);
    else
      case (cmd)
        CMD_ACT: bad = !bank_idle[sel]; // RULE_05
        CMD_RD, CMD_WR: bad = (st[sel] != BK_OPEN) || ap[sel]; // RULE_10
        CMD_REF: bad = (bank_idle != '1);
        default: bad = 1'b0;
      endcase
  end

  // one-cycle flag, late by one clock
  always_ff @(posedge core_clk) begin
    if (reset)
      cmd_err <= 1'b0;
    else
      cmd_err <= bad;
  end
endmodule : dbr_dev

// *** dbr_if.sv ***
`timescale 1ns/10ps
// command/address bus from controller to memory
interface dbr_if;
  logic cs_n;
  logic act_n;
  logic [1:0] bg;
  logic [1:0] ba;
  logic [17:0] addr;
  logic [2:0] fgr_mode;
  modport ctl (output cs_n, act_n, bg, ba, addr, fgr_mode);
  modport dev (input cs_n, act_n, bg, ba, addr, fgr_mode);
endinterface : dbr_if

// *** dbr_pkg.sv ***
// Contract
// (RULE_01) activate opens addressed row until precharge
// (RULE_02) precharge before opening another row
// (RULE_03) activate spacing short across groups, long within
// (RULE_04) at most four activates per window
// (RULE_05) precharge closes bank; reuse after tRP
// (RULE_06) precharge idle bank allowed; last restarts timer
// (RULE_07) activate before any read or write
// (RULE_08) A10 high auto-precharges after array restore
// (RULE_09) write auto-precharge waits for stored data
// (RULE_10) other-bank access allowed during auto-precharge
// (RULE_11) refresh decode: cs, ras, cas low, we high
// (RULE_12) all banks idle tRP before refresh
// (RULE_13) refresh row from internal counter only
// (RULE_14) refresh leaves all banks precharged idle
// (RULE_15) only deselect until tRFC expires
// (RULE_16) one refresh per interval on average
// (RULE_17) postpone at most 8, 16, 32
// (RULE_18) surrounding refresh gap bounded per mode
// (RULE_19) pull in up to 8, 16, 32 only
// (RULE_20) burst cap 16, 32, 64 refreshes
// (RULE_21) three-bit refresh mode, five valid codes
// (RULE_22) on-the-fly modes sample bg0 per refresh
// (RULE_23) device tracks per-bank idle, open, precharging
// (RULE_24) controller keeps bounded signed refresh debt
package dbr_pkg;
  localparam int CLK_NS = 40;
  localparam int BG_W = 2;
  localparam int BA_W = 2;
  localparam int NBG = 4;
  localparam int NBANK = 16;
  localparam int ROW_W = 18;
  localparam int COL_W = 10;
  localparam int REF_W = 16;
  localparam int AP_BIT = 10;
  localparam int TMR_W = 12;
  // least times in ns, counts rounded up
  localparam int T_RP_NS = 15;
  localparam int T_RCD_NS = 15;
  localparam int T_RRD_S_NS = 5;
  localparam int T_RRD_L_NS = 7;
  localparam int T_FAW_NS = 30;
  localparam int T_RTP_NS = 8;
  localparam int T_WR_NS = 15;
  localparam int T_RFC_NS = 350;
  localparam int T_RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RRD_S_CYC = (T_RRD_S_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RRD_L_CYC = (T_RRD_L_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_FAW_CYC = (T_FAW_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RTP_CYC = (T_RTP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RFC_CYC = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
  // one burst of eight occupies four clocks
  localparam int T_BURST_CYC = 4;
  localparam int T_WRAP_CYC = T_BURST_CYC + T_WR_CYC;
  // longest time, rounded down
  localparam int T_REFI_NS = 7800;
  localparam int T_REFI_CYC = T_REFI_NS / CLK_NS;
  localparam int POST_BASE = 8;
  // refresh mode codes
  localparam logic [2:0] FGR_1X = 3'h0;
  localparam logic [2:0] FGR_2X = 3'h1;
  localparam logic [2:0] FGR_4X = 3'h2;
  localparam logic [2:0] FGR_OTF2 = 3'h5;
  localparam logic [2:0] FGR_OTF4 = 3'h6;

  typedef enum logic [2:0] {
    CMD_DES = 3'b000,
    CMD_NOP = 3'b001,
    CMD_ACT = 3'b010,
    CMD_PRE = 3'b011,
    CMD_RD = 3'b100,
    CMD_WR = 3'b101,
    CMD_REF = 3'b110,
    CMD_MISC = 3'b111
  } dbr_cmd_t;

  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_OPEN = 2'b01,
    BK_PRE = 2'b10
  } dbr_bank_t;

  // rcw holds ras_n, cas_n, we_n (a16, a15, a14)
  function automatic dbr_cmd_t dbr_decode(input logic cs_n,
      input logic act_n, input logic [2:0] rcw);
    dbr_cmd_t c;
    c = CMD_MISC;
    if (cs_n)
      c = CMD_DES;
    else if (!act_n)
      c = CMD_ACT;
    else
      case (rcw)
        3'h1: c = CMD_REF; // RULE_11
        3'h2: c = CMD_PRE;
        3'h5: c = CMD_RD;
        3'h4: c = CMD_WR;
        3'h7: c = CMD_NOP;
        default: c = CMD_MISC;
      endcase
    return c;
  endfunction : dbr_decode

  function automatic logic [2:0] dbr_rcw(input dbr_cmd_t c);
    case (c)
      CMD_REF: return 3'h1;
      CMD_PRE: return 3'h2;
      CMD_RD: return 3'h5;
      CMD_WR: return 3'h4;
      default: return 3'h7;
    endcase
  endfunction : dbr_rcw

  // rate shift 0, 1, 2 for 1x, 2x, 4x; reserved codes act as 1x
  function automatic logic [1:0] dbr_shift(input logic [2:0] mode,
      input logic bg0);
    case (mode)
      FGR_2X: return 2'h1;
      FGR_4X: return 2'h2;
      FGR_OTF2: return bg0 ? 2'h1 : 2'h0; // RULE_22
      FGR_OTF4: return bg0 ? 2'h2 : 2'h0;
      default: return 2'h0; // RULE_21
    endcase
  endfunction : dbr_shift
endpackage : dbr_pkg

// *** dbr_sva.sv ***
`timescale 1ns/10ps
module dbr_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command bus
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  input wire logic [2:0] fgr_mode
);
  import dbr_pkg::*;
  // nine base intervals bound the gap, with or without pull-ins
  localparam int GAP_MAX = 9 * T_REFI_CYC;
  logic [3:0] bk;
  logic is_act;
  logic is_ref;
  logic is_pre;
  logic is_rw;
  logic is_ap;
  logic [NBANK-1:0] open_map;
  logic [3:0] ap_bank;
  logic [2:0] ap_cnt;
  logic [12:0] gap_cnt;

  // raw decode of the bus, kept apart from the design's own decoder
  assign bk = {bg, ba};
  assign is_act = !cs_n && !act_n;
  assign is_ref = !cs_n && act_n && addr[16:14] == 3'h1;
  assign is_pre = !cs_n && act_n && addr[16:14] == 3'h2;
  assign is_rw = !cs_n && act_n && addr[16:15] == 2'h2;
  assign is_ap = is_rw && addr[AP_BIT];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // open rows; auto-precharge closes at once here, lockout kept apart
  always_ff @(posedge core_clk) begin
    if (reset)
      open_map <= '0;
    else if (is_act)
      open_map[bk] <= 1'b1;
    else if (is_pre && addr[AP_BIT])
      open_map <= '0;
    else if (is_pre || is_ap)
      open_map[bk] <= 1'b0;
  end

  // lockout of the last auto-precharged bank (read: addr[14] high)
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ap_cnt <= 3'h0;
      ap_bank <= 4'h0;
    end else if (is_ap) begin
      ap_bank <= bk;
      ap_cnt <= addr[14] ? 3'(T_RTP_CYC + T_RP_CYC - 1) :
        3'(T_WRAP_CYC + T_RP_CYC - 1);
    end else if (ap_cnt != 3'h0) begin
      ap_cnt <= ap_cnt - 3'h1;
    end
  end

  // cycles since the last refresh, only counted in fixed 1x mode
  always_ff @(posedge core_clk) begin
    if (reset || is_ref || fgr_mode != FGR_1X)
      gap_cnt <= 13'h0;
    else if (gap_cnt != 13'h1FFF)
      gap_cnt <= gap_cnt + 13'h1;
  end

  sequence s_ref;
    is_ref;
  endsequence
  sequence s_quiet;
    cs_n [*8] ##1 cs_n;
  endsequence

  a_ref_des_only: assert property (s_ref |=> s_quiet)
    else $error("command issued inside refresh cycle");
  a_ref_all_idle: assert property (is_ref |->
      open_map == '0 && ap_cnt == 3'h0)
    else $error("refresh with a bank not idle");
  a_act_idle_bank: assert property (is_act |-> !open_map[bk])
    else $error("activate to a bank with an open row");
  a_act_after_ap: assert property (is_act && bk == ap_bank
      |-> ap_cnt == 3'h0)
    else $error("activate before auto-precharge finished");
  a_rw_open_bank: assert property (is_rw |-> open_map[bk])
    else $error("read or write to a bank without open row");
  a_rw_burst_gap: assert property (is_rw |=> !is_rw [*3])
    else $error("access cuts into a running burst");
  a_otf_fine_rate: assert property (is_ref && fgr_mode[2] |-> bg[0])
    else $error("on-the-fly refresh without rate select");
  a_ref_gap_bound: assert property (gap_cnt < GAP_MAX)
    else $error("refresh gap too long");
endmodule : dbr_sva

// *** ddr4_bank_row_refresh_rules_tb.sv ***
`timescale 1ns/10ps
module ddr4_bank_row_refresh_rules_tb;
  import dbr_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] fgr_mode_cfg = FGR_1X;
  logic pull_en = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_ap = 1'b0;
  logic [1:0] req_bg = 2'h0;
  logic [1:0] req_ba = 2'h0;
  logic [ROW_W-1:0] req_row = '0;
  logic [COL_W-1:0] req_col = '0;
  logic req_ready;
  logic ref_active;
  logic ref_busy;
  logic cmd_err;
  logic signed [6:0] ref_debt;
  logic [NBANK-1:0] bank_open;
  logic [REF_W-1:0] ref_row;
  logic [1:0] ref_shift;
  int n_errors = 0;
  int cmp_count = 0;
  int err_pulses = 0;
  int cycles = 0;
  logic [3:0] banks [4] = '{4'h0, 4'h5, 4'h1, 4'hA};
  logic [2:0] modes [5] = '{FGR_2X, FGR_4X, FGR_OTF2, FGR_OTF4, 3'h3};
  int shifts [5] = '{1, 2, 1, 2, 0};

  always #20 core_clk = ~core_clk;

  dbr_if u_dbr_if ();
  dbr_ctl u_dbr_ctl (.core_clk(core_clk), .reset(reset),
    .bus(u_dbr_if.ctl), .fgr_mode_cfg(fgr_mode_cfg), .pull_en(pull_en),
    .req_valid(req_valid), .req_write(req_write), .req_ap(req_ap),
    .req_bg(req_bg), .req_ba(req_ba), .req_row(req_row),
    .req_col(req_col), .req_ready(req_ready), .ref_debt(ref_debt),
    .ref_active(ref_active));
  dbr_dev u_dbr_dev (.core_clk(core_clk), .reset(reset),
    .bus(u_dbr_if.dev), .bank_open(bank_open), .ref_row(ref_row),
    .ref_shift(ref_shift), .ref_busy(ref_busy), .cmd_err(cmd_err));
  dbr_sva u_dbr_sva (.core_clk(core_clk), .reset(reset),
    .cs_n(u_dbr_if.cs_n), .act_n(u_dbr_if.act_n), .bg(u_dbr_if.bg),
    .ba(u_dbr_if.ba), .addr(u_dbr_if.addr), .fgr_mode(u_dbr_if.fgr_mode));

  task check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // one burst request, held until the controller takes it
  task access(input logic wr, input logic ap, input logic [3:0] bank,
      input logic [ROW_W-1:0] row);
    int n;
    n = 0;
    tick(1);
    {req_bg, req_ba} = bank;
    req_write = wr;
    req_ap = ap;
    req_row = row;
    req_col = row[COL_W-1:0];
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    check("request taken", 1, n < 4000);
    tick(1);
    req_valid = 1'b0;
  endtask : access

  // waits for a refresh and measures how long the device stays busy
  task wait_ref;
    int n;
    n = 0;
    while (ref_busy !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    check("refresh start", 1, n < 4000);
    check("controller in refresh", 1, ref_active);
    n = 0;
    while (ref_busy === 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("refresh length", T_RFC_CYC, n);
  endtask : wait_ref

  // cycle ceiling well above the longest refresh waits
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("mismatch watchdog expected done seen timeout");
      test_done;
    end
  end

  // every refused command counts
  always @(posedge core_clk) begin
    if (!reset && cmd_err === 1'b1)
      err_pulses++;
  end

  initial begin
    repeat (6) @(posedge core_clk);
    #1 reset = 1'b0;
    check("bank_open at reset", 0, bank_open);
    check("ref_row at reset", 0, ref_row);
    check("ref_debt at reset", 0, ref_debt);
    access(1'b0, 1'b0, 4'h5, 18'h00123);
    tick(2);
    check("row open", 1, bank_open[5]);
    access(1'b1, 1'b0, 4'h5, 18'h3FFFF);
    tick(2);
    check("row reopened", 1, bank_open[5]);
    access(1'b1, 1'b1, 4'h5, 18'h3FFFF);
    tick(3);
    check("write restore hold", 1, bank_open[5]);
    tick(8);
    check("write ap closed", 0, bank_open[5]);
    // same-group and cross-group banks, back to back with auto-precharge
    for (int i = 0; i < 4; i++)
      access(i[0], 1'b1, banks[i], ROW_W'(i));
    tick(12);
    check("all auto closed", 0, bank_open);
    // leave a row open so refresh must close it first
    access(1'b0, 1'b0, 4'h3, 18'h00001);
    wait_ref;
    check("banks idle after refresh", 0, bank_open);
    check("refresh row count", 1, ref_row);
    check("refresh rate 1x", 0, ref_shift);
    check("postpone limit", 1, ref_debt <= 8);
    pull_en = 1'b1;
    for (int m = 0; m < 5; m++) begin
      fgr_mode_cfg = modes[m];
      wait_ref;
      wait_ref;
      check("refresh rate", shifts[m], ref_shift);
      check("pull-in floor", 1, ref_debt >= -(8 << shifts[m]));
    end
    check("refused commands", 0, err_pulses);
    test_done;
  end
endmodule : ddr4_bank_row_refresh_rules_tb
